// file: su_pkg.sv
package su_pkg;

  localparam logic [7:0] SU_LIT_OPC        = 8'h08;
  localparam logic [5:0] SU_FILE_OPC       = 6'h17;
  localparam logic [5:0] SU_FILEB_OPC      = 6'h16;
  localparam int         SU_DEST_BIT       = 9;
  localparam int         SU_BANK_BIT       = 8;
  localparam int         SU_FLAG_C         = 0;
  localparam int         SU_FLAG_DC        = 1;
  localparam int         SU_FLAG_Z         = 2;
  localparam int         SU_FLAG_OV        = 3;
  localparam int         SU_FLAG_N         = 4;
  localparam logic [7:0] SU_WORKING_REGISTER_RST       = 8'h00;
  localparam logic [4:0] SU_FLAGS_RST      = 5'h00;
  localparam logic [3:0] SU_ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] SU_ACCESS_HI_BANK = 4'hf;
  localparam int         SU_INSTR_CYCLES   = 1;

  typedef enum logic [1:0] {
    SU_OP_NONE,
    SU_OP_LIT,
    SU_OP_FILE,
    SU_OP_FILEB
  } su_op_t;

  function automatic su_op_t su_decode(input logic [15:0] word);
    su_op_t op;
    op = SU_OP_NONE;
    if (word[15:8] == SU_LIT_OPC) begin
      op = SU_OP_LIT;
    end else if (word[15:10] == SU_FILE_OPC) begin
      op = SU_OP_FILE;
    end else if (word[15:10] == SU_FILEB_OPC) begin
      op = SU_OP_FILEB;
    end
    return op;
  endfunction

endpackage

// file: su_sub_if.sv
`timescale 1ns/10ps
`default_nettype none
interface su_sub_if;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [7:0] res;
  logic       c;
  logic       dc;
  logic       ov;
  logic       n;
  logic       z;
  modport calc (input a, b, cin, output res, c, dc, ov, n, z);
  modport user (output a, b, cin, input res, c, dc, ov, n, z);
endinterface
`default_nettype wire

// file: su_sub.sv
`timescale 1ns/10ps
`default_nettype none
// Computes a - b - !cin as a + ~b + cin, so carry out means no borrow.
module su_sub (
  su_sub_if.calc s
);
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;

  assign lo_sum = {1'b0, s.a[3:0]} + {1'b0, ~s.b[3:0]} + {4'h0, s.cin};
  assign hi_sum = {1'b0, s.a[7:4]} + {1'b0, ~s.b[7:4]} + {4'h0, lo_sum[4]};
  assign s.res  = {hi_sum[3:0], lo_sum[3:0]};
  assign s.dc   = lo_sum[4];
  assign s.c    = hi_sum[4];
  assign s.ov   = (s.a[7] != s.b[7]) && (s.res[7] != s.a[7]);
  assign s.n    = s.res[7];
  assign s.z    = (s.res == 8'h00);
endmodule
`default_nettype wire

// file: su_unit.sv
`timescale 1ns/10ps
`default_nettype none
module su_unit
  import su_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [3:0]  bank_select_register_i,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        working_register_wr_i,
  input  wire logic [7:0]  working_register_wdata_i,
  input  wire logic        flags_wr_i,
  input  wire logic [4:0]  flags_wdata_i,
  output logic      [11:0] mem_raddr_o,
  output logic      [11:0] mem_waddr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             mem_we_o,
  output logic      [7:0]  working_register_o,
  output logic      [4:0]  flags_o,
  output logic             done_o
);
  import su_pkg::*;

  su_op_t     op;
  logic       is_file;
  logic       exec;
  logic [3:0] bank;
  logic [7:0] working_register_q;
  logic [4:0] flags_q;
  logic [4:0] flags_d;
  logic [11:0] waddr_q;
  logic [7:0] wdata_q;
  logic       we_q;
  logic       done_q;

  su_sub_if sub ();

  su_sub u_sub (
    .s (sub)
  );

  assign op      = su_decode(instr_i);
  assign is_file = (op == SU_OP_FILE) || (op == SU_OP_FILEB);
  assign exec    = instr_valid_i && (op != SU_OP_NONE);

  // Access bank splits the 8-bit address: low half in bank 0, high half in the top bank.
  always_comb begin
    if (instr_i[SU_BANK_BIT]) begin
      bank = bank_select_register_i;
    end else if (instr_i[7]) begin
      bank = SU_ACCESS_HI_BANK;
    end else begin
      bank = SU_ACCESS_LO_BANK;
    end
  end

  assign mem_raddr_o = {bank, instr_i[7:0]};

  always_comb begin
    sub.b = working_register_q;
    if (op == SU_OP_LIT) begin
      sub.a = instr_i[7:0];
    end else begin
      sub.a = mem_rdata_i;
    end
    if (op == SU_OP_FILEB) begin
      sub.cin = flags_q[SU_FLAG_C];
    end else begin
      sub.cin = 1'b1;
    end
  end

  always_comb begin
    flags_d             = 5'h00;
    flags_d[SU_FLAG_C]  = sub.c;
    flags_d[SU_FLAG_DC] = sub.dc;
    flags_d[SU_FLAG_Z]  = sub.z;
    flags_d[SU_FLAG_OV] = sub.ov;
    flags_d[SU_FLAG_N]  = sub.n;
  end

  // An executing subtract takes priority over a software load of the same register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      working_register_q <= SU_WORKING_REGISTER_RST;
    end else if (ce_i) begin
      if (exec && ((op == SU_OP_LIT) || !instr_i[SU_DEST_BIT])) begin
        working_register_q <= sub.res;
      end else if (working_register_wr_i) begin
        working_register_q <= working_register_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= SU_FLAGS_RST;
    end else if (ce_i) begin
      if (exec) begin
        flags_q <= flags_d;
      end else if (flags_wr_i) begin
        flags_q <= flags_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      we_q    <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 8'h00;
    end else if (ce_i) begin
      we_q <= exec && is_file && instr_i[SU_DEST_BIT];
      if (exec && is_file) begin
        waddr_q <= mem_raddr_o;
        wdata_q <= sub.res;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= exec;
    end
  end

  assign mem_we_o           = we_q;
  assign mem_waddr_o        = waddr_q;
  assign mem_wdata_o        = wdata_q;
  assign working_register_o = working_register_q;
  assign flags_o            = flags_q;
  assign done_o             = done_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence lit_go_s;
    ce_i && instr_valid_i && (op == SU_OP_LIT);
  endsequence

  sequence file_go_s;
    ce_i && instr_valid_i && is_file;
  endsequence

  lit_result_a : assert property (lit_go_s |=>
    working_register_q == 8'($past(instr_i[7:0]) - $past(working_register_q)))
    else $error("literal subtract result wrong");

  lit_operand_a : assert property (lit_go_s |=>
    flags_q[SU_FLAG_Z] == ($past(instr_i[7:0]) == $past(working_register_q)))
    else $error("literal operand not low byte");

  file_result_a : assert property ((file_go_s ##0 (op == SU_OP_FILE)
    ##0 instr_i[SU_DEST_BIT]) |=>
    mem_we_o && mem_wdata_o == 8'($past(mem_rdata_i) - $past(working_register_q)))
    else $error("file subtract result wrong");

  borrow_result_a : assert property ((file_go_s ##0 (op == SU_OP_FILEB)) |=>
    mem_wdata_o == 8'($past(mem_rdata_i) - $past(working_register_q) - 8'({7'h00, !$past(flags_q[0])})))
    else $error("borrow subtract result wrong");

  zero_flag_a : assert property ((ce_i && exec) |=>
    flags_q[SU_FLAG_Z] == ($past(sub.res) == 8'h00) && flags_q[SU_FLAG_N] == $past(sub.res[7]))
    else $error("zero or negative flag wrong");

  one_cycle_a : assert property (lit_go_s |=> done_o)
    else $error("subtract not done in one cycle");

  dest_select_a : assert property ((file_go_s ##0 !instr_i[SU_DEST_BIT]) |=>
    !mem_we_o && working_register_q == $past(sub.res))
    else $error("destination select wrong");

  bank_select_a : assert property (file_go_s |->
    mem_raddr_o[11:8] == (instr_i[SU_BANK_BIT] ? bank_select_register_i :
                          (instr_i[7] ? SU_ACCESS_HI_BANK : SU_ACCESS_LO_BANK)))
    else $error("bank select wrong");

  carry_borrow_a : assert property (lit_go_s |=>
    flags_q[SU_FLAG_C] == ($past(instr_i[7:0]) >= $past(working_register_q)))
    else $error("carry not inverted borrow");

  file_carry_a : assert property ((file_go_s ##0 (op == SU_OP_FILE)) |=>
    flags_q[SU_FLAG_C] == ($past(mem_rdata_i) >= $past(working_register_q)))
    else $error("file carry not inverted borrow");

  lit_overflow_a : assert property (lit_go_s |=> flags_q[SU_FLAG_OV] ==
    (($past(instr_i[7]) != $past(working_register_q[7])) && (working_register_q[7] != $past(instr_i[7]))))
    else $error("literal overflow flag wrong");

  lit_digit_a : assert property (lit_go_s |=>
    flags_q[SU_FLAG_DC] == ($past(instr_i[3:0]) >= $past(working_register_q[3:0])))
    else $error("literal digit carry wrong");

  dest_write_a : assert property ((file_go_s ##0 instr_i[SU_DEST_BIT] ##0 !working_register_wr_i) |=>
    mem_we_o && mem_waddr_o == $past(mem_raddr_o) && working_register_o == $past(working_register_q))
    else $error("file destination write wrong");

  unknown_op_a : assert property ((ce_i && instr_valid_i && (instr_i[15:8] != SU_LIT_OPC)
    && (instr_i[15:11] != SU_FILE_OPC[5:1])) |=> !done_o)
    else $error("unknown opcode reported done");

  // A low clock enable must hold every piece of state, including a pending write strobe.
  freeze_hold_a : assert property (!ce_i |=> $stable(working_register_q) && $stable(flags_q)
    && $stable(mem_we_o) && $stable(done_o))
    else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// file: su_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Data memory beside the unit: combinational read, write at the clock edge.
module su_mem_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] raddr_i,
  input  wire logic [11:0] waddr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:4095];
  assign rdata_o = mem[raddr_i];
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// file: su_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module su_unit_tb;
  import su_pkg::*;
  logic        clk_i, rst_i, ce_i, valid, wr_w, wr_f, we, done, c_exp;
  logic [15:0] instr;
  logic [3:0]  bank_select_register;
  logic [7:0]  rdata, wd, w_o, mwd, w_exp;
  logic [4:0]  fd, fl, f_exp;
  logic [11:0] ra, wa;
  int          n_mismatch, checks_done;

  su_unit u_su_unit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_valid_i(valid),
    .instr_i(instr), .bank_select_register_i(bank_select_register), .mem_rdata_i(rdata), .working_register_wr_i(wr_w),
    .working_register_wdata_i(wd), .flags_wr_i(wr_f), .flags_wdata_i(fd), .mem_raddr_o(ra),
    .mem_waddr_o(wa), .mem_wdata_o(mwd), .mem_we_o(we), .working_register_o(w_o),
    .flags_o(fl), .done_o(done));
  su_mem_model u_su_mem_model (.clk_i(clk_i), .raddr_i(ra), .waddr_i(wa), .wdata_i(mwd),
    .we_i(we), .rdata_o(rdata));

  // Result in bits 7:0, flags {N,OV,Z,DC,C} in bits 12:8.
  function automatic logic [12:0] sub_ref(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    return {s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic load(input logic [7:0] w, input logic [4:0] f);
    wd = w;
    fd = f;
    wr_w = 1'b1;
    wr_f = 1'b1;
    @(negedge clk_i);
    wr_w = 1'b0;
    wr_f = 1'b0;
    w_exp = w;
    c_exp = f[0];
    f_exp = f;
  endtask

  task automatic do_op(input logic [15:0] ins, input logic [7:0] fv);
    logic        lit;
    logic [11:0] ad;
    logic [12:0] r;
    lit = ins[15:8] == SU_LIT_OPC;
    ad = {ins[8] ? bank_select_register : (ins[7] ? 4'hf : 4'h0), ins[7:0]};
    u_su_mem_model.mem[ad] = fv;
    r = sub_ref(lit ? ins[7:0] : fv, w_exp, (ins[15:10] == SU_FILEB_OPC) ? c_exp : 1'b1);
    instr = ins;
    valid = 1'b1;
    #1;
    if (!lit) check("raddr", ra, ad);
    @(negedge clk_i);
    valid = 1'b0;
    check("done", {11'h0, done}, 12'h001);
    check("flags", {7'h0, fl}, {7'h0, r[12:8]});
    f_exp = r[12:8];
    if (lit || !ins[9]) begin
      check("working_register", {4'h0, w_o}, {4'h0, r[7:0]});
      check("we", {11'h0, we}, 12'h000);
      w_exp = r[7:0];
    end else begin
      check("waddr", wa, ad);
      check("working_register kept", {4'h0, w_o}, {4'h0, w_exp});
      check("we high", {11'h0, we}, 12'h001);
      check("wdata", {4'h0, mwd}, {4'h0, r[7:0]});
    end
    c_exp = r[8];
    @(negedge clk_i);
    check("done end", {11'h0, done}, 12'h000);
    if (!lit && ins[9]) check("mem", {4'h0, u_su_mem_model.mem[ad]}, {4'h0, r[7:0]});
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {ce_i, valid, wr_w, wr_f, instr, bank_select_register, wd, fd} = '0;
    rst_i = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    ce_i = 1'b1;
    load(8'h01, 5'h00);
    do_op(16'h0802, 8'h00);
    do_op(16'h08ff, 8'h00);
    load(8'h03, 5'h00);
    do_op(16'h0802, 8'h00);
    bank_select_register = 4'h2;
    load(8'h02, 5'h00);
    do_op(16'h5f10, 8'h03);
    do_op(16'h5e85, 8'h02);
    do_op(16'h5c10, 8'h05);
    load(8'h0d, 5'h00);
    do_op(16'h5b20, 8'h19);
    do_op(16'h5a30, 8'h80);
    do_op(16'h5830, 8'h40);
    instr = 16'h5410;
    valid = 1'b1;
    @(negedge clk_i);
    check("unknown op", {11'h0, done}, 12'h000);
    check("unknown working_register", {4'h0, w_o}, {4'h0, w_exp});
    check("unknown flags", {7'h0, fl}, {7'h0, f_exp});
    instr = 16'h0802;
    ce_i = 1'b0;
    @(negedge clk_i);
    check("ce low", {4'h0, w_o}, {4'h0, w_exp});
    check("ce low flags", {7'h0, fl}, {7'h0, f_exp});
    check("ce low done", {11'h0, done}, 12'h000);
    ce_i = 1'b1;
    wd = 8'haa;
    fd = 5'h1f;
    wr_w = 1'b1;
    wr_f = 1'b1;
    do_op(16'h0810, 8'h00);
    wr_w = 1'b0;
    wr_f = 1'b0;
    check("working_register load", {4'h0, w_o}, 12'h0aa);
    check("flags load", {7'h0, fl}, 12'h01f);
    conclude();
  end
endmodule
`default_nettype wire
